// *** src/mcr_pkg.sv ***
// package for the monitor configuration register bank
// assumes an apb slave with 32-bit data, one register per word
package mcr_pkg;

    // =====================================================================
    // register indices (printed offsets are not multiples of four)
    localparam logic [7:0] MCR_IDX_CODING_GPIO = 8'h7c;
    localparam logic [7:0] MCR_IDX_PIN_SCALING = 8'h7d;
    localparam logic [7:0] MCR_IDX_TEST_A = 8'h7e;
    localparam logic [7:0] MCR_IDX_TEST_B = 8'h7f;
    localparam logic [7:0] MCR_IDX_LOCK_CTRL = 8'h80;

    // =====================================================================
    // reset values
    localparam logic [7:0] MCR_RST_CODING_GPIO = 8'h00;
    localparam logic [7:0] MCR_RST_PIN_SCALING = 8'h00;
    localparam logic [7:0] MCR_RST_TEST = 8'h00;

    // =====================================================================
    // field positions
    localparam int MCR_BIT_TWOS = 0;
    localparam int MCR_BIT_PWMF = 1;
    localparam int MCR_BIT_GPIO_DIRECTION = 2;
    localparam int MCR_BIT_GPIO_POLARITY = 3;
    localparam logic [7:0] MCR_CODING_MASK = 8'h0f;
    localparam int MCR_BIT_LOCK = 0;

    // =====================================================================
    // shared pin routing
    typedef enum logic [1:0] {
        MCR_PIN_FAN4 = 2'b00,
        MCR_PIN_THERMAL_ALARM_PIN = 2'b01,
        MCR_PIN_ALERT = 2'b10,
        MCR_PIN_GPIO = 2'b11
    } mcr_pin_fn_t;

    typedef struct packed {
        logic bypass_12v_divider;
        logic bypass_5v_divider;
        logic bypass_core_supply_divider;
        logic bypass_2v5_divider;
        logic [1:0] two_wire_tach_threshold;
        mcr_pin_fn_t shared_pin_function;
    } mcr_pin_cfg_t;

    typedef struct packed {
        logic twos_complement_select;
        logic pwm_freq_select;
        logic gpio_output;
        logic gpio_active_high;
    } mcr_core_cfg_t;

endpackage

// *** src/mcr_regs.sv ***
// register bank: coding/gpio config, pin/scaling config, two test regs
// assumes an apb master on clk; lock bit held in a register of its own
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module mcr_regs
    import mcr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoded configuration to the monitor engines
    output mcr_core_cfg_t core_cfg,
    output mcr_pin_cfg_t pin_cfg,
    output logic lock_active
);

    // =====================================================================
    // state
    logic [7:0] coding_r, coding_nxt;
    logic [7:0] pin_r, pin_nxt;
    logic lock_r, lock_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic rdy_r;

    // =====================================================================
    // decode
    function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
        return a == {2'b00, i, 2'b00};
    endfunction

    wire logic access_w = psel && !penable;
    // a write lands only at the access edge where pready is sampled high
    wire logic wr_w = psel && penable && pready && pwrite;
    wire logic sel_cod = hit(paddr, MCR_IDX_CODING_GPIO);
    wire logic sel_pin = hit(paddr, MCR_IDX_PIN_SCALING);
    wire logic sel_ta = hit(paddr, MCR_IDX_TEST_A);
    wire logic sel_tb = hit(paddr, MCR_IDX_TEST_B);
    wire logic sel_lck = hit(paddr, MCR_IDX_LOCK_CTRL);
    wire logic mapped = sel_cod | sel_pin | sel_ta | sel_tb | sel_lck;

    // lock is sticky until reset, so it cannot be used to unlock itself
    assign lock_nxt = lock_r | (wr_w && sel_lck && pwdata[MCR_BIT_LOCK]);
    assign coding_nxt = (wr_w && sel_cod && !lock_r)
        ? (pwdata[7:0] & MCR_CODING_MASK) : coding_r;
    assign pin_nxt = (wr_w && sel_pin && !lock_r) ? pwdata[7:0] : pin_r;

    // test registers have no storage: writes fall away, reads give zero
    assign rdata_nxt = !access_w || pwrite ? 32'h0000_0000 :
        sel_cod ? {24'h00_0000, coding_r} :
        sel_pin ? {24'h00_0000, pin_r} :
        sel_lck ? {31'h0000_0000, lock_r} :
        {24'h00_0000, MCR_RST_TEST};
    assign err_nxt = access_w && !mapped;

    // =====================================================================
    // registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coding_r <= MCR_RST_CODING_GPIO;
            pin_r <= MCR_RST_PIN_SCALING;
            lock_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
            rdy_r <= 1'b0;
        end else begin
            coding_r <= coding_nxt;
            pin_r <= pin_nxt;
            lock_r <= lock_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            rdy_r <= access_w;
        end
    end

    // =====================================================================
    // outputs: no wait state, answer flopped in the setup cycle
    assign prdata = rdata_r;
    assign pready = rdy_r;
    assign pslverr = err_r;
    assign lock_active = lock_r;
    // engines reinterpret stored limits from this bit with no latency
    assign core_cfg.twos_complement_select = coding_r[MCR_BIT_TWOS];
    assign core_cfg.pwm_freq_select = coding_r[MCR_BIT_PWMF];
    // direction only matters when the shared pin is routed to gpio
    assign core_cfg.gpio_output = coding_r[MCR_BIT_GPIO_DIRECTION];
    assign core_cfg.gpio_active_high = coding_r[MCR_BIT_GPIO_POLARITY];
    assign pin_cfg = mcr_pin_cfg_t'(pin_r);

    // =====================================================================
    // checks
    a_lock_blocks_cod: assert property (@(posedge clk) disable iff (!resetn)
        lock_r |=> $stable(coding_r))
        else $error("coding register changed while locked");
    a_lock_blocks_pin: assert property (@(posedge clk) disable iff (!resetn)
        lock_r |=> $stable(pin_r))
        else $error("pin register changed while locked");
    a_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
        coding_r[7:4] == 4'h0)
        else $error("upper coding bits not zero");
    a_write_cod: assert property (@(posedge clk) disable iff (!resetn)
        wr_w && sel_cod && !lock_r
        |=> coding_r == ($past(pwdata[7:0]) & MCR_CODING_MASK))
        else $error("coding write not stored");
    a_write_pin: assert property (@(posedge clk) disable iff (!resetn)
        wr_w && sel_pin && !lock_r |=> pin_r == $past(pwdata[7:0]))
        else $error("pin write not stored");
    a_test_read: assert property (@(posedge clk) disable iff (!resetn)
        access_w && !pwrite && (sel_ta || sel_tb) |=> prdata == 32'h0)
        else $error("test register read not zero");
    a_twos_follow: assert property (@(posedge clk) disable iff (!resetn)
        core_cfg.twos_complement_select == coding_r[0])
        else $error("coding select mismatch");
    a_ready_once: assert property (@(posedge clk) disable iff (!resetn)
        access_w |=> pready ##1 !pready)
        else $error("pready not one cycle");
    a_pin_thresh: assert property (@(posedge clk) disable iff (!resetn)
        pin_cfg.two_wire_tach_threshold == pin_r[3:2])
        else $error("threshold mismatch");
    c_lock: cover property (@(posedge clk) disable iff (!resetn)
        !lock_r ##1 lock_r);
    c_locked_write: cover property (@(posedge clk) disable iff (!resetn)
        lock_r && wr_w && sel_pin);
    c_gpio: cover property (@(posedge clk) disable iff (!resetn)
        pin_cfg.shared_pin_function == MCR_PIN_GPIO);
    c_err: cover property (@(posedge clk) disable iff (!resetn) pslverr);

endmodule

`default_nettype wire

// *** dv/mcr_regs_tb_top.sv ***
// testbench for the monitor configuration register bank
// assumes the apb slave answers once per transfer; bench drives ports
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    n_errors++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end end

module mcr_regs_tb_top
    import mcr_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    mcr_core_cfg_t core_cfg;
    mcr_pin_cfg_t pin_cfg;
    logic lock_active;
    int n_errors = 0, n_tests = 0;
    // row: address, write data, read-back, error, {core_cfg, pin_cfg}
    localparam logic [40:0] ROWS [12] = '{
        {12'h1f0, 8'h01, 8'h01, 1'b0, 12'h800}, {12'h1f0, 8'hff, 8'h0f, 1'b0, 12'hf00},
        {12'h1f0, 8'h0a, 8'h0a, 1'b0, 12'h500}, {12'h1f0, 8'h04, 8'h04, 1'b0, 12'h200},
        {12'h1f4, 8'h01, 8'h01, 1'b0, 12'h201}, {12'h1f4, 8'h02, 8'h02, 1'b0, 12'h202},
        {12'h1f4, 8'h03, 8'h03, 1'b0, 12'h203}, {12'h1f4, 8'h0c, 8'h0c, 1'b0, 12'h20c},
        {12'h1f4, 8'hf0, 8'hf0, 1'b0, 12'h2f0}, {12'h1f8, 8'hff, 8'h00, 1'b0, 12'h2f0},
        {12'h1fc, 8'hff, 8'h00, 1'b0, 12'h2f0}, {12'h300, 8'hff, 8'h00, 1'b1, 12'h2f0}};

    mcr_regs i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_cfg(core_cfg),
        .pin_cfg(pin_cfg), .lock_active(lock_active));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // =====================================================================
    // apb master: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic complete_run();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        `CHK({core_cfg, pin_cfg, lock_active}, 13'h0)
        foreach (ROWS[i]) begin
            apb(1'b1, ROWS[i][40:29], ROWS[i][28:21]);
            `CHK(er, ROWS[i][12])
            apb(1'b0, ROWS[i][40:29], 8'h00);
            `CHK(rd, {24'h0, ROWS[i][20:13]})
            `CHK(er, ROWS[i][12])
            `CHK({core_cfg, pin_cfg}, ROWS[i][11:0])
        end
        // lock, then both configuration writes must be dropped
        apb(1'b1, 12'h200, 8'h01);
        apb(1'b1, 12'h1f0, 8'h0f);
        `CHK(lock_active, 1'b1)
        apb(1'b1, 12'h1f4, 8'h00);
        apb(1'b0, 12'h1f0, 8'h00);
        `CHK(rd, 32'h04)
        apb(1'b0, 12'h1f4, 8'h00);
        `CHK(rd, 32'hf0)
        `CHK({core_cfg, pin_cfg}, 12'h2f0)
        // second reset in mid-run clears the lock and both configs
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        `CHK({core_cfg, pin_cfg, lock_active}, 13'h0)
        apb(1'b0, 12'h1f0, 8'h00);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h1f4, 8'h00);
        `CHK(rd, 32'h0)
        complete_run();
    end

    // a hang ends the run as a counted mismatch
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
